// ### src/dsp_consts.vh
`ifndef DSP_CONSTS_VH
`define DSP_CONSTS_VH

// Register offsets (word addresses on the plain register port)
`define DSP_OFS_CTRL_A      4'h0
`define DSP_OFS_CTRL_B      4'h1
`define DSP_OFS_COUNT       4'h2
`define DSP_OFS_CMP_A       4'h3
`define DSP_OFS_CMP_B       4'h4
`define DSP_OFS_CAPTURE     4'h5
`define DSP_OFS_FLAGS       4'h6
`define DSP_OFS_REQ_EN      4'h7
`define DSP_OFS_PIN_DIR     4'h8

// Field positions in the first control register
`define DSP_CA_ACT_A_HI     7
`define DSP_CA_ACT_A_LO     6
`define DSP_CA_ACT_B_HI     5
`define DSP_CA_ACT_B_LO     4
`define DSP_CA_MODE_HI      1
`define DSP_CA_MODE_LO      0

// Field positions in the second control register
`define DSP_CB_MODE_HI      4
`define DSP_CB_MODE_LO      3
`define DSP_CB_PRE_HI       2
`define DSP_CB_PRE_LO       0

// Flag bit positions
`define DSP_FL_OVF          0
`define DSP_FL_CMP_A        1
`define DSP_FL_CMP_B        2
`define DSP_FL_CAPT         5

// Waveform modes handled here
`define DSP_MODE_CAPT_TOP   4'h8
`define DSP_MODE_CMPA_TOP   4'h9

// Output action codes
`define DSP_ACT_OFF         2'h0
`define DSP_ACT_TOGGLE      2'h1
`define DSP_ACT_NONINV      2'h2
`define DSP_ACT_INV         2'h3

// Prescale divisions
`define DSP_DIV_8           11'h008
`define DSP_DIV_64          11'h040
`define DSP_DIV_256         11'h100
`define DSP_DIV_1024        11'h400

// Reset values
`define DSP_RST_BYTE        8'h00
`define DSP_RST_WORD        16'h0000
`define DSP_RST_PRE_CNT     11'h000

`endif

// ### src/dsp_timer.v
// Decided for this implementation: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`include "dsp_consts.vh"

module dsp_timer #(
   parameter CNT_W = 16
) (
   // Clock and reset
   input  wire              mclk,
   input  wire              srst,
   // Register port
   input  wire [3:0]        reg_addr,
   input  wire [CNT_W-1:0]  reg_wdata,
   input  wire              reg_wr,
   input  wire              reg_rd,
   output wire [CNT_W-1:0]  reg_rdata,
   // Normal port data shown when the compare output is disconnected
   input  wire              port_dat_a,
   input  wire              port_dat_b,
   // Compare output pins, enable low while driving
   output wire              compare_output_a,
   output wire              compare_output_a_oe_n,
   output wire              compare_output_b,
   output wire              compare_output_b_oe_n,
   // Per-flag interrupt requests
   output wire [3:0]        irq_req
);

   // Control and data registers
   reg  [7:0]        ctrl_a_q;      // Output actions, low mode bits
   reg  [7:0]        ctrl_b_q;      // High mode bits, prescale select
   reg  [CNT_W-1:0]  counter_value_q;
   reg               count_up_q;    // Current slope direction
   reg  [CNT_W-1:0]  cmp_buf_q [0:1];
   reg  [CNT_W-1:0]  cmp_act_q [0:1];
   reg  [CNT_W-1:0]  capture_top_value_q;
   reg  [5:0]        flags_q;       // Sticky event flags
   reg  [5:0]        req_en_q;      // Request enables per flag
   reg  [1:0]        pin_direction_bit_q;
   reg  [CNT_W-1:0]  rdata_q;
   reg  [10:0]       pre_cnt_q;     // Prescale divider count

   // Decoded controls and internal strobes
   wire [3:0]        waveform_mode_select;
   wire [1:0]        output_action [0:1];
   wire              pwm_mode;
   wire              mode_cmpa_top;
   wire [CNT_W-1:0]  top_value;
   wire              timer_tick;
   wire              at_top;
   wire              at_bottom;
   wire              slope_up;
   wire [1:0]        match;
   wire [1:0]        connected;
   wire [1:0]        wave;
   wire [1:0]        port_dat;
   wire [1:0]        buf_wr;
   wire [5:0]        flag_set;
   wire [5:0]        flag_clr;
   wire [10:0]       pre_div;

   // Division factor for a prescale select code; zero means stopped
   // Select codes outside the table stop the divider as well
   function [10:0] div_of;
      input [2:0] sel;
      begin
         case (sel)
            3'h1:    div_of = 11'h001;
            3'h2:    div_of = `DSP_DIV_8;
            3'h3:    div_of = `DSP_DIV_64;
            3'h4:    div_of = `DSP_DIV_256;
            3'h5:    div_of = `DSP_DIV_1024;
            default: div_of = 11'h000;
         endcase
      end
   endfunction

   // Mode select gathered from both control registers
   // Any other mode leaves the counter and both outputs idle
   assign waveform_mode_select = {ctrl_b_q[`DSP_CB_MODE_HI:`DSP_CB_MODE_LO],
                                  ctrl_a_q[`DSP_CA_MODE_HI:`DSP_CA_MODE_LO]};
   assign output_action[0] = ctrl_a_q[`DSP_CA_ACT_A_HI:`DSP_CA_ACT_A_LO];
   assign output_action[1] = ctrl_a_q[`DSP_CA_ACT_B_HI:`DSP_CA_ACT_B_LO];
   assign mode_cmpa_top    = (waveform_mode_select == `DSP_MODE_CMPA_TOP);
   assign pwm_mode         = mode_cmpa_top ||
                             (waveform_mode_select == `DSP_MODE_CAPT_TOP);

   // TOP source follows the mode
   // Compare A as TOP is buffered, so a live change of it stays glitch free
   assign top_value = mode_cmpa_top ? cmp_act_q[0] : capture_top_value_q;

   // Prescaler: tick is a one-cycle enable, never a derived clock
   assign pre_div    = div_of(ctrl_b_q[`DSP_CB_PRE_HI:`DSP_CB_PRE_LO]);
   assign timer_tick = (pre_div != 11'h000) && (pre_cnt_q == pre_div - 11'h001);

   // Divider restarts whenever it wraps or is stopped
   // It counts from zero to the division minus one, one tick per wrap
   always @(posedge mclk) begin
      if (srst || timer_tick || (pre_div == 11'h000)) begin
         pre_cnt_q <= `DSP_RST_PRE_CNT;
      end else begin
         pre_cnt_q <= pre_cnt_q + 11'h001;
      end
   end

   // Turning points; the slope at TOP counts as down, at BOTTOM as up,
   // so that the extreme compare values give steady levels
   assign at_top    = (counter_value_q == top_value);
   assign at_bottom = (counter_value_q == `DSP_RST_WORD);
   assign slope_up  = at_bottom ? 1'b1 : (at_top ? 1'b0 : count_up_q);

   // Buffer writes from software
   // Software only reaches the buffers; the active copies load at BOTTOM
   assign buf_wr[0] = reg_wr && (reg_addr == `DSP_OFS_CMP_A);
   assign buf_wr[1] = reg_wr && (reg_addr == `DSP_OFS_CMP_B);
   assign port_dat  = {port_dat_b, port_dat_a};

   // Up/down counter; a software write to the count wins over the tick
   always @(posedge mclk) begin
      if (srst) begin
         counter_value_q <= `DSP_RST_WORD;
         count_up_q      <= 1'b1;
      end else if (reg_wr && (reg_addr == `DSP_OFS_COUNT)) begin
         counter_value_q <= reg_wdata;
      end else if (timer_tick && pwm_mode) begin
         // BOTTOM is tested first: straight after reset the active compare A
         // is still zero, and a TOP of zero must not send the count below zero
         if (at_bottom) begin
            // BOTTOM was shown for this one tick, now turn up
            count_up_q      <= 1'b1;
            counter_value_q <= counter_value_q + {{(CNT_W-1){1'b0}}, 1'b1};
         end else if (at_top) begin
            // TOP was shown for this one tick, now turn down
            count_up_q      <= 1'b0;
            counter_value_q <= counter_value_q - {{(CNT_W-1){1'b0}}, 1'b1};
         end else if (count_up_q) begin
            counter_value_q <= counter_value_q + {{(CNT_W-1){1'b0}}, 1'b1};
         end else begin
            counter_value_q <= counter_value_q - {{(CNT_W-1){1'b0}}, 1'b1};
         end
      end
   end

   // Per-channel compare buffer, match and waveform
   genvar ch;
   generate
      for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
         // Waveform flop of this channel, kept across mode changes
         reg wave_q;
         wire toggle_ok;

         // Toggle action exists only on channel A with compare A as TOP
         assign toggle_ok = (ch == 0) && mode_cmpa_top;

         // A compare value above TOP can never be reached
         assign match[ch] = timer_tick && pwm_mode &&
                            (counter_value_q == cmp_act_q[ch]) &&
                            (cmp_act_q[ch] <= top_value);

         // Connected for actions two and three, or toggle where allowed
         assign connected[ch] = pwm_mode && (output_action[ch][1] ||
                                ((output_action[ch] == `DSP_ACT_TOGGLE) && toggle_ok));

         // Buffered compare; active copy loads at BOTTOM only
         always @(posedge mclk) begin
            if (srst) begin
               cmp_buf_q[ch] <= `DSP_RST_WORD;
               cmp_act_q[ch] <= `DSP_RST_WORD;
            end else begin
               if (buf_wr[ch]) begin
                  cmp_buf_q[ch] <= reg_wdata;
               end
               if (timer_tick && pwm_mode && at_bottom) begin
                  cmp_act_q[ch] <= cmp_buf_q[ch];
               end
            end
         end

         // Output compare register
         always @(posedge mclk) begin
            if (srst) begin
               wave_q <= 1'b0;
            end else if (match[ch]) begin
               case (output_action[ch])
                  `DSP_ACT_NONINV: wave_q <= ~slope_up;
                  `DSP_ACT_INV:    wave_q <= slope_up;
                  `DSP_ACT_TOGGLE: begin
                     if (toggle_ok) begin
                        wave_q <= ~wave_q;
                     end
                  end
                  default:         wave_q <= wave_q;
               endcase
            end
         end

         assign wave[ch] = wave_q;
      end
   endgenerate

   // Pin drive: waveform or normal port data, enable from direction bit
   // The enable is live even while disconnected, so port data reaches the pin
   assign compare_output_a      = connected[0] ? wave[0] : port_dat[0];
   assign compare_output_b      = connected[1] ? wave[1] : port_dat[1];
   assign compare_output_a_oe_n = ~pin_direction_bit_q[0];
   assign compare_output_b_oe_n = ~pin_direction_bit_q[1];

   // Flag events; compare A at TOP is covered by its own match in mode 9
   assign flag_set[`DSP_FL_OVF]   = timer_tick && pwm_mode && at_bottom;
   assign flag_set[`DSP_FL_CMP_A] = match[0] ||
                                    (timer_tick && mode_cmpa_top && at_top);
   assign flag_set[`DSP_FL_CMP_B] = match[1];
   // Bits 4:3 have no event behind them and always read zero
   assign flag_set[4:3]           = 2'h0;
   assign flag_set[`DSP_FL_CAPT]  = timer_tick && pwm_mode && !mode_cmpa_top && at_top;

   // Writing one to a flag clears it
   // A zero in the written word leaves that flag alone
   assign flag_clr = (reg_wr && (reg_addr == `DSP_OFS_FLAGS)) ? reg_wdata[5:0] : 6'h00;

   // Sticky flags; a set in the clearing cycle wins
   // Reset clears every flag and with it every request
   always @(posedge mclk) begin
      if (srst) begin
         flags_q <= 6'h00;
      end else begin
         flags_q <= (flags_q & ~flag_clr) | flag_set;
      end
   end

   // Requests follow enabled flags
   // Only the four flags that exist reach the request outputs
   assign irq_req = {flags_q[`DSP_FL_CAPT], flags_q[`DSP_FL_CMP_B:`DSP_FL_OVF]} &
                    {req_en_q[`DSP_FL_CAPT], req_en_q[`DSP_FL_CMP_B:`DSP_FL_OVF]};

   // Plain register writes
   // Reserved control bits are masked so that they always read zero
   // Unmapped addresses fall to the default branch and change nothing
   always @(posedge mclk) begin
      if (srst) begin
         ctrl_a_q            <= `DSP_RST_BYTE;
         ctrl_b_q            <= `DSP_RST_BYTE;
         capture_top_value_q <= `DSP_RST_WORD;
         req_en_q            <= 6'h00;
         pin_direction_bit_q <= 2'h0;
      end else if (reg_wr) begin
         case (reg_addr)
            `DSP_OFS_CTRL_A:  ctrl_a_q <= reg_wdata[7:0] & 8'hF3;
            `DSP_OFS_CTRL_B:  ctrl_b_q <= reg_wdata[7:0] & 8'h1F;
            // Capture TOP is unbuffered; changing it live may skew a period
            `DSP_OFS_CAPTURE: capture_top_value_q <= reg_wdata;
            `DSP_OFS_REQ_EN:  req_en_q <= reg_wdata[5:0] & 6'h27;
            `DSP_OFS_PIN_DIR: pin_direction_bit_q <= reg_wdata[1:0];
            default:          ctrl_a_q <= ctrl_a_q;
         endcase
      end
   end

   // Read data stands only in the cycle after the strobe
   // Outside the read slot the port shows zero, never a stale word
   always @(posedge mclk) begin
      if (srst || !reg_rd) begin
         rdata_q <= `DSP_RST_WORD;
      end else begin
         case (reg_addr)
            `DSP_OFS_CTRL_A:  rdata_q <= {8'h00, ctrl_a_q};
            `DSP_OFS_CTRL_B:  rdata_q <= {8'h00, ctrl_b_q};
            `DSP_OFS_COUNT:   rdata_q <= counter_value_q;
            `DSP_OFS_CMP_A:   rdata_q <= cmp_buf_q[0];
            `DSP_OFS_CMP_B:   rdata_q <= cmp_buf_q[1];
            `DSP_OFS_CAPTURE: rdata_q <= capture_top_value_q;
            `DSP_OFS_FLAGS:   rdata_q <= {10'h000, flags_q};
            `DSP_OFS_REQ_EN:  rdata_q <= {10'h000, req_en_q};
            `DSP_OFS_PIN_DIR: rdata_q <= {14'h0000, pin_direction_bit_q};
            default:          rdata_q <= `DSP_RST_WORD;
         endcase
      end
   end

   assign reg_rdata = rdata_q;

endmodule

// ### testbench/dsp_timer_checker.sv
`timescale 1ns/1ps
`include "dsp_consts.vh"
module dsp_timer_checker #(
   parameter CNT_W = 16
) (
   // Clock, reset and register port
   input wire logic             mclk,
   input wire logic             srst,
   input wire logic [3:0]       reg_addr,
   input wire logic [CNT_W-1:0] reg_wdata,
   input wire logic             reg_wr,
   input wire logic             reg_rd,
   input wire logic [CNT_W-1:0] reg_rdata,
   // Pins and requests
   input wire logic             port_dat_a,
   input wire logic             port_dat_b,
   input wire logic             compare_output_a,
   input wire logic             compare_output_a_oe_n,
   input wire logic             compare_output_b,
   input wire logic             compare_output_b_oe_n,
   input wire logic [3:0]       irq_req
);
   reg  [3:0] act_q;                 // Shadow of both output action fields
   wire       dir_wr = reg_wr && reg_addr == `DSP_OFS_PIN_DIR;
   // Only these writes may legally drop a pending request
   wire       drop_wr = reg_wr && (reg_addr == `DSP_OFS_FLAGS || reg_addr == `DSP_OFS_REQ_EN);
   default clocking @(posedge mclk); endclocking
   default disable iff (srst);
   // Track the action fields on the same edge the block takes them
   always @(posedge mclk) begin
      if (srst) act_q <= 4'h0;
      else if (reg_wr && reg_addr == `DSP_OFS_CTRL_A) act_q <= reg_wdata[7:4];
   end
   a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
      else $error("read data not zero outside read slot");
   a_ctrl_reserved: assert property ($past(reg_rd) && $past(reg_addr) == `DSP_OFS_CTRL_A |->
      reg_rdata[15:8] == 8'h00 && reg_rdata[3:2] == 2'h0) else $error("reserved control bits set");
   a_unmapped_zero: assert property ($past(reg_rd) && $past(reg_addr) > 4'h8 |-> reg_rdata == 16'h0000)
      else $error("unmapped read not zero");
   a_dir_a_drive: assert property (dir_wr |=> compare_output_a_oe_n == !$past(reg_wdata[0]))
      else $error("pin A enable does not follow direction");
   a_dir_b_drive: assert property (dir_wr |=> compare_output_b_oe_n == !$past(reg_wdata[1]))
      else $error("pin B enable does not follow direction");
   a_port_a_off: assert property (act_q[3:2] == `DSP_ACT_OFF |-> compare_output_a == port_dat_a)
      else $error("pin A not showing port data");
   a_port_b_off: assert property (act_q[1:0] < `DSP_ACT_NONINV |-> compare_output_b == port_dat_b)
      else $error("pin B not showing port data");
   a_flag_sticky: assert property (!$past(srst) && !$past(drop_wr) |->
      (irq_req & $past(irq_req)) == $past(irq_req)) else $error("request dropped without clear");
   a_irq_masked: assert property (reg_wr && reg_addr == `DSP_OFS_REQ_EN && reg_wdata == 16'h0000 |=>
      irq_req == 4'h0) else $error("request with all enables off");
   c_read_data: cover property (reg_rd ##1 reg_rdata != 16'h0000);
   c_pin_drive: cover property ($fell(compare_output_b_oe_n));
   c_request: cover property (irq_req != 4'h0);
endmodule
bind dsp_timer dsp_timer_checker #(.CNT_W(CNT_W)) dsp_timer_checker_i (
   .mclk(mclk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .port_dat_a(port_dat_a), .port_dat_b(port_dat_b), .compare_output_a(compare_output_a),
   .compare_output_a_oe_n(compare_output_a_oe_n), .compare_output_b(compare_output_b),
   .compare_output_b_oe_n(compare_output_b_oe_n), .irq_req(irq_req));

// ### testbench/dsp_timer_tb_top.sv
`timescale 1ns/1ps
`include "dsp_consts.vh"
module dsp_timer_tb_top;
   reg          mclk = 1'b0;
   reg          srst = 1'b1;
   reg  [3:0]   reg_addr = 4'h0;
   reg  [15:0]  reg_wdata = 16'h0000;
   reg          reg_wr = 1'b0;
   reg          reg_rd = 1'b0;
   reg          port_dat_a = 1'b0;
   reg          port_dat_b = 1'b0;
   wire [15:0]  reg_rdata;
   wire         oa, oa_oe_n, ob, ob_oe_n;
   wire [3:0]   irq_req;
   int          err_total = 0;
   int          comparisons = 0;
   logic [15:0] v[$], q[$], runs[$];   // Raw reads, distinct values, run lengths
   logic [15:0] ha, hb, top, ca, cb, fl, dv;
   int          k, it, md, en, act;
   always #50 mclk = ~mclk;
   // Port data toggles randomly so a disconnected pin is really watched
   always @(posedge mclk) begin
      port_dat_a <= $urandom;
      port_dat_b <= $urandom;
   end
   dsp_timer dsp_timer_i (.mclk(mclk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .port_dat_a(port_dat_a), .port_dat_b(port_dat_b),
      .compare_output_a(oa), .compare_output_a_oe_n(oa_oe_n), .compare_output_b(ob),
      .compare_output_b_oe_n(ob_oe_n), .irq_req(irq_req));
   task chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons = comparisons + 1;
      if (got !== exp) begin
         err_total = err_total + 1;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task give_verdict;
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge mclk) begin reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d; end
      @(posedge mclk) reg_wr <= 1'b0;
   endtask
   // Back-to-back reads, one result per cycle into v
   task rd_burst(input logic [3:0] a, input int n);
      v = {};
      @(posedge mclk) begin reg_rd <= 1'b1; reg_addr <= a; end
      for (int j = 0; j < n; j++) begin
         @(posedge mclk);
         if (j == n - 1) reg_rd <= 1'b0;
         #1 v.push_back(reg_rdata);
      end
   endtask
   // High cycles over four slopes; toggle is high for exactly half
   function logic [15:0] exp_high(input int a, input int c, input int t, input int n);
      exp_high = (a == 1) ? 2 * t * n : (a == 2) ? 4 * c * n : 4 * (t - c) * n;
   endfunction
   // Next distinct count: turn round at TOP and at zero
   function logic [15:0] exp_next(input logic [15:0] p, input logic [15:0] c, input logic [15:0] t);
      exp_next = (c == t) ? c - 16'h0001 : (c == 16'h0000) ? 16'h0001 : c + c - p;
   endfunction
   // Hang guard
   initial begin
      repeat (100000) @(posedge mclk);
      err_total = err_total + 1;
      give_verdict;
   end
   initial begin
      void'($urandom(32'h4dd10b92));
      repeat (3) @(posedge mclk);
      srst <= 1'b0;
      #1 chk({15'h0, ob_oe_n}, 16'h0001);
      for (k = 0; k < 16; k++) begin
         rd_burst(k[3:0], 1);
         chk(v[0], 16'h0000);
      end
      for (it = 0; it < 8; it++) begin
         md = $urandom_range(1);
         top = (it == 0) ? 16'h0003 : $urandom_range(40, 3);
         cb = (it == 1) ? top : (it == 2) ? top + 1 : (it == 0) ? 16'h0000 : $urandom_range(top);
         ca = $urandom_range(top);
         act = $urandom_range(3, 2);
         dv = (it % 2) ? 16'h0008 : 16'h0001;
         en = $urandom_range(15);
         wr(`DSP_OFS_REQ_EN, 16'h0000);
         wr(`DSP_OFS_CTRL_B, 16'h0010);
         wr(`DSP_OFS_CTRL_A, {8'h0, md ? 2'h1 : 2'(5 - act), 2'(act), 3'h0, 1'(md)});
         wr(`DSP_OFS_CAPTURE, top);
         wr(`DSP_OFS_CMP_A, md ? top : ca);
         wr(`DSP_OFS_CMP_B, cb);
         wr(`DSP_OFS_PIN_DIR, 16'h0003);
         wr(`DSP_OFS_COUNT, 16'h0000);
         wr(`DSP_OFS_FLAGS, 16'h0027);
         rd_burst(`DSP_OFS_FLAGS, 1);
         chk(v[0], 16'h0000);
         wr(`DSP_OFS_REQ_EN, {10'h0, 1'(en >> 3), 2'h0, 3'(en)});
         wr(`DSP_OFS_CTRL_B, (dv == 16'h0001) ? 16'h0011 : 16'h0012);
         repeat (4 * top * dv) @(posedge mclk);
         ha = 16'h0000;
         hb = 16'h0000;
         repeat (4 * top * dv) begin
            @(posedge mclk);
            #1 ha = ha + oa;
            hb = hb + ob;
         end
         chk(ha, md ? exp_high(1, top, top, dv) : exp_high(5 - act, ca, top, dv));
         if (cb <= top) chk(hb, exp_high(act, cb, top, dv));
         rd_burst(`DSP_OFS_COUNT, (2 * top + 4) * dv);
         q = {};
         runs = {};
         foreach (v[j]) begin
            if (j > 0 && v[j] === v[j-1]) runs[$] = runs[$] + 16'h0001;
            else begin q.push_back(v[j]); runs.push_back(16'h0001); end
         end
         chk({15'h0, q.size() >= 2 * top + 2}, 16'h0001);
         for (k = 1; k + 1 < q.size(); k++) chk(runs[k], dv);
         for (k = 2; k < q.size(); k++) chk(q[k], exp_next(q[k-2], q[k-1], top));
         rd_burst(`DSP_OFS_FLAGS, 1);
         fl = {10'h0, md == 0, 2'h0, cb <= top, 2'h3};
         chk(v[0], fl);
         chk({12'h0, irq_req}, {12'h0, {fl[5], fl[2:0]} & 4'(en)});
      end
      wr(`DSP_OFS_PIN_DIR, 16'h0000);
      #1 chk({14'h0, oa_oe_n, ob_oe_n}, 16'h0003);
      give_verdict;
   end
endmodule
